// ---- hw/shp_port.v ----
/*
  serial host handshake port: half-duplex asynchronous receiver with
  message buffer, request-to-send holdoff, and paced reply transmitter.
  assumes the command parser sits on the message/reply ports and that
  the serial and handshake inputs are already synchronous to clk_i.
  the parser delivers its reply as bytes ending in a line-feed.
*/
//
// Contract
// - data-terminal-ready held true after reset
// - start bit triggers character receive into buffer
// - characters without carrier detect are discarded
// - keep buffering until line-feed arrives
// - line-feed asserts request-to-send holdoff
// - clear-to-send and set-ready gate each character
// - negate holdoff after reply terminator sent
// - request-to-send negated right after reset
// - switches force handshake inputs true
// - polarity switch open inverts request-to-send
// - eight switch-selected bit rates, half duplex
// - seven or eight data bits
// - odd, even or no parity
// - two stop bits barred with 8+parity
// - discarded characters flag syntax error
// - parity mismatch flags parity error
// - buffer overflow flags overrun error
// - carriage return before line-feed optional
`timescale 1ns/100ps
`default_nettype none
`include "shp_defs.vh"

module shp_port #(parameter RATE_SHIFT = 0) (
  input  wire                    clk_i,
  input  wire                    reset_i,
  input  wire [2:0]              sw_baud_i,
  input  wire                    sw_eight_bits_i,
  input  wire [1:0]              sw_parity_i,
  input  wire                    sw_two_stop_i,
  input  wire                    sw_force_dcd_i,
  input  wire                    sw_force_cts_i,
  input  wire                    sw_force_dsr_i,
  input  wire                    sw_rts_open_i,
  input  wire                    rxd_i,
  input  wire                    cts_i,
  input  wire                    dsr_i,
  input  wire                    dcd_i,
  output reg                     txd_o,
  output reg                     rts_o,
  output reg                     dtr_o,
  output reg                     msg_ready_o,
  output reg  [`SHP_BUF_AW:0]    msg_len_o,
  output reg  [1:0]              msg_err_o,
  input  wire [`SHP_BUF_AW-1:0]  msg_raddr_i,
  output wire [7:0]              msg_rdata_o,
  input  wire                    reply_valid_i,
  output reg                     reply_ready_o,
  input  wire [7:0]              reply_data_i
);
  localparam RX_IDLE  = 4'b0001;
  localparam RX_START = 4'b0010;
  localparam RX_BITS  = 4'b0100;
  localparam RX_STOP  = 4'b1000;
  localparam TX_IDLE  = 4'b0001;
  localparam TX_WAIT  = 4'b0010;
  localparam TX_SHIFT = 4'b0100;
  localparam TX_DONE  = 4'b1000;

  // configuration caught once after reset release
  reg                    cfg_done_ff;
  reg [`SHP_DIV_W-1:0]   div_ff;
  reg                    eight_ff;
  reg [1:0]              par_ff;
  reg                    two_stop_ff;
  reg                    f_dcd_ff;
  reg                    f_cts_ff;
  reg                    f_dsr_ff;
  reg                    rts_inv_ff;
  reg [31:0]             nxt_div;
  wire [31:0]            div_sel = nxt_div >> RATE_SHIFT; // nonzero only to shorten bit times

  always @* begin
    case (sw_baud_i)
      3'h0:    nxt_div = `SHP_DIV_75;
      3'h1:    nxt_div = `SHP_DIV_150;
      3'h2:    nxt_div = `SHP_DIV_300;
      3'h3:    nxt_div = `SHP_DIV_600;
      3'h4:    nxt_div = `SHP_DIV_1200;
      3'h5:    nxt_div = `SHP_DIV_2400;
      3'h6:    nxt_div = `SHP_DIV_4800;
      default: nxt_div = `SHP_DIV_9600;
    endcase
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_done_ff <= 1'b0;
      div_ff      <= {`SHP_DIV_W{1'b0}};
      eight_ff    <= 1'b1;
      par_ff      <= `SHP_PAR_NONE;
      two_stop_ff <= 1'b0;
      f_dcd_ff    <= 1'b1;
      f_cts_ff    <= 1'b1;
      f_dsr_ff    <= 1'b1;
      rts_inv_ff  <= 1'b0;
    end else if (!cfg_done_ff) begin
      cfg_done_ff <= 1'b1;
      div_ff      <= div_sel[`SHP_DIV_W-1:0];
      eight_ff    <= sw_eight_bits_i;
      par_ff      <= sw_parity_i;
      // 8 data bits with parity leave room for one stop bit only
      two_stop_ff <= sw_two_stop_i & ~(sw_eight_bits_i & (sw_parity_i != `SHP_PAR_NONE));
      f_dcd_ff    <= sw_force_dcd_i;
      f_cts_ff    <= sw_force_cts_i;
      f_dsr_ff    <= sw_force_dsr_i;
      rts_inv_ff  <= sw_rts_open_i;
    end
  end

  wire dcd_ok = f_dcd_ff | dcd_i;
  wire cts_ok = f_cts_ff | cts_i;
  wire dsr_ok = f_dsr_ff | dsr_i;
  wire [3:0] nbits = {3'h0, (par_ff != `SHP_PAR_NONE)} + (eight_ff ? 4'h8 : 4'h7);

  // message state: holdoff from line-feed until reply line-feed has left
  reg busy_ff;

  // receiver
  reg [3:0]              rx_st_ff;
  reg [`SHP_DIV_W-1:0]   rx_cnt_ff;
  reg [3:0]              rx_bit_ff;
  reg [8:0]              rx_sh_ff;
  reg                    rx_dcd_ff;
  reg [`SHP_BUF_AW:0]    wr_ptr_ff;
  reg                    e_syn_ff;
  reg                    e_par_ff;
  reg                    e_ovr_ff;
  reg                    rx_we_ff;
  reg [7:0]              rx_wd_ff;
  reg [`SHP_BUF_AW-1:0]  rx_wa_ff;

  wire [7:0] rx_char = eight_ff ? rx_sh_ff[7:0] : {1'b0, rx_sh_ff[6:0]};
  wire       rx_pbit = eight_ff ? rx_sh_ff[8] : rx_sh_ff[7];
  wire       rx_par_bad = (par_ff == `SHP_PAR_ODD)  ? ~(^rx_char ^ rx_pbit) :
                          (par_ff == `SHP_PAR_EVEN) ?  (^rx_char ^ rx_pbit) : 1'b0;
  wire       rx_mid = (rx_cnt_ff == {1'b0, div_ff[`SHP_DIV_W-1:1]});
  wire       rx_end = (rx_cnt_ff == div_ff - 1'b1);

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_st_ff    <= RX_IDLE;
      rx_cnt_ff   <= {`SHP_DIV_W{1'b0}};
      rx_bit_ff   <= 4'h0;
      rx_sh_ff    <= 9'h000;
      rx_dcd_ff   <= 1'b0;
      wr_ptr_ff   <= {(`SHP_BUF_AW+1){1'b0}};
      e_syn_ff    <= 1'b0;
      e_par_ff    <= 1'b0;
      e_ovr_ff    <= 1'b0;
      rx_we_ff    <= 1'b0;
      rx_wd_ff    <= 8'h00;
      rx_wa_ff    <= {`SHP_BUF_AW{1'b0}};
      msg_ready_o <= 1'b0;
      msg_len_o   <= {(`SHP_BUF_AW+1){1'b0}};
      msg_err_o   <= `SHP_ERR_NONE;
    end else begin
      rx_we_ff    <= 1'b0;
      msg_ready_o <= 1'b0;
      case (rx_st_ff)
        RX_IDLE: begin
          rx_cnt_ff <= {`SHP_DIV_W{1'b0}};
          // while holding off the line is ignored: half duplex
          if (cfg_done_ff && !busy_ff && !rxd_i) begin
            rx_st_ff <= RX_START;
          end
        end
        RX_START: begin
          rx_cnt_ff <= rx_cnt_ff + 1'b1;
          if (rx_mid) begin
            rx_cnt_ff <= {`SHP_DIV_W{1'b0}};
            rx_bit_ff <= 4'h0;
            rx_dcd_ff <= dcd_ok;
            // a glitch shorter than half a bit is not a start
            rx_st_ff  <= rxd_i ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          rx_cnt_ff <= rx_cnt_ff + 1'b1;
          if (rx_end) begin
            rx_cnt_ff <= {`SHP_DIV_W{1'b0}};
            rx_sh_ff[rx_bit_ff] <= rxd_i;
            rx_bit_ff <= rx_bit_ff + 1'b1;
            if (rx_bit_ff == nbits - 1'b1) begin
              rx_st_ff <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          rx_cnt_ff <= rx_cnt_ff + 1'b1;
          if (rx_end) begin
            rx_st_ff <= RX_IDLE;
            if (!rx_dcd_ff) begin
              e_syn_ff <= 1'b1;
            end else if (rx_char == `SHP_CHAR_LF) begin
              // a leading CR is just another stored byte
              msg_ready_o <= 1'b1;
              msg_len_o   <= wr_ptr_ff;
              msg_err_o   <= e_ovr_ff ? `SHP_ERR_OVERRUN :
                             (e_par_ff | rx_par_bad) ? `SHP_ERR_PARITY :
                             e_syn_ff ? `SHP_ERR_SYNTAX : `SHP_ERR_NONE;
              wr_ptr_ff   <= {(`SHP_BUF_AW+1){1'b0}};
              e_syn_ff    <= 1'b0;
              e_par_ff    <= 1'b0;
              e_ovr_ff    <= 1'b0;
            end else begin
              if (rx_par_bad) begin
                e_par_ff <= 1'b1;
              end
              if (wr_ptr_ff == `SHP_BUF_DEPTH) begin
                e_ovr_ff <= 1'b1;
              end else begin
                rx_we_ff  <= 1'b1;
                rx_wd_ff  <= rx_char;
                rx_wa_ff  <= wr_ptr_ff[`SHP_BUF_AW-1:0];
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
              end
            end
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  shp_msg_ram u_ram (
    .clk_i   (clk_i),
    .we_i    (rx_we_ff),
    .waddr_i (rx_wa_ff),
    .wdata_i (rx_wd_ff),
    .raddr_i (msg_raddr_i),
    .rdata_o (msg_rdata_o)
  );

  // reply path
  wire       rb_in_ready;
  wire       rb_valid;
  wire [7:0] rb_data;
  reg        rb_pop;
  wire       rb_push = reply_valid_i & reply_ready_o;

  shp_skid_buf u_buf (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (rb_push),
    .in_ready_o  (rb_in_ready),
    .in_data_i   (reply_data_i),
    .out_valid_o (rb_valid),
    .out_ready_i (rb_pop),
    .out_data_o  (rb_data)
  );

  reg [3:0]             tx_st_ff;
  reg [`SHP_DIV_W-1:0]  tx_cnt_ff;
  reg [3:0]             tx_bit_ff;
  reg [11:0]            tx_sh_ff;
  reg                   tx_last_ff;
  wire [3:0]            tx_total = nbits + (two_stop_ff ? 4'h2 : 4'h1);
  wire [7:0]            tx_char  = eight_ff ? rb_data : {1'b0, rb_data[6:0]};
  wire                  tx_pbit  = (par_ff == `SHP_PAR_ODD) ? ~(^tx_char) : ^tx_char;

  always @* begin
    rb_pop = (tx_st_ff == TX_WAIT) && rb_valid && cts_ok && dsr_ok;
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_st_ff      <= TX_IDLE;
      tx_cnt_ff     <= {`SHP_DIV_W{1'b0}};
      tx_bit_ff     <= 4'h0;
      tx_sh_ff      <= 12'hfff;
      tx_last_ff    <= 1'b0;
      busy_ff       <= 1'b0;
      txd_o         <= 1'b1;
      rts_o         <= 1'b0;
      dtr_o         <= 1'b0;
      reply_ready_o <= 1'b0;
    end else begin
      dtr_o         <= 1'b1;
      // the switch is read live on the first edge so rts does not show asserted after reset
      rts_o         <= busy_ff ^ (cfg_done_ff ? rts_inv_ff : sw_rts_open_i);
      reply_ready_o <= rb_in_ready & busy_ff & ~rb_push; // never overstates room
      case (tx_st_ff)
        TX_IDLE: begin
          txd_o <= 1'b1;
          if (busy_ff) begin
            tx_st_ff <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          // handshake looked at only here, once per character
          if (rb_pop) begin
            tx_last_ff <= (rb_data == `SHP_CHAR_LF);
            tx_sh_ff   <= eight_ff ?
                          (par_ff == `SHP_PAR_NONE ? {3'h7, tx_char, 1'b0} :
                                                     {2'h3, tx_pbit, tx_char, 1'b0}) :
                          (par_ff == `SHP_PAR_NONE ? {4'hf, tx_char[6:0], 1'b0} :
                                                     {3'h7, tx_pbit, tx_char[6:0], 1'b0});
            tx_cnt_ff  <= {`SHP_DIV_W{1'b0}};
            tx_bit_ff  <= 4'h0;
            tx_st_ff   <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          txd_o     <= tx_sh_ff[0];
          tx_cnt_ff <= tx_cnt_ff + 1'b1;
          if (tx_cnt_ff == div_ff - 1'b1) begin
            tx_cnt_ff <= {`SHP_DIV_W{1'b0}};
            tx_sh_ff  <= {1'b1, tx_sh_ff[11:1]};
            tx_bit_ff <= tx_bit_ff + 1'b1;
            if (tx_bit_ff == tx_total) begin
              tx_st_ff <= tx_last_ff ? TX_DONE : TX_WAIT;
            end
          end
        end
        TX_DONE: begin
          txd_o    <= 1'b1;
          busy_ff  <= 1'b0;
          tx_st_ff <= TX_IDLE;
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
      if (msg_ready_o) begin
        busy_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/shp_defs.vh ----
/*
  constants of the serial host handshake port: bit-rate divisors,
  character framing, receive buffer size and error codes.
  assumes a 250 MHz device clock.
*/
`ifndef SHP_DEFS_VH
`define SHP_DEFS_VH

`define SHP_CLK_HZ       250000000
`define SHP_DIV_W        22
// clocks per bit = clock rate / baud
`define SHP_DIV_75       (`SHP_CLK_HZ / 75)
`define SHP_DIV_150      (`SHP_CLK_HZ / 150)
`define SHP_DIV_300      (`SHP_CLK_HZ / 300)
`define SHP_DIV_600      (`SHP_CLK_HZ / 600)
`define SHP_DIV_1200     (`SHP_CLK_HZ / 1200)
`define SHP_DIV_2400     (`SHP_CLK_HZ / 2400)
`define SHP_DIV_4800     (`SHP_CLK_HZ / 4800)
`define SHP_DIV_9600     (`SHP_CLK_HZ / 9600)

`define SHP_PAR_NONE     2'h0
`define SHP_PAR_ODD      2'h1
`define SHP_PAR_EVEN     2'h2

`define SHP_CHAR_LF      8'h0a
`define SHP_CHAR_CR      8'h0d

`define SHP_BUF_AW       6
`define SHP_BUF_DEPTH    64

`define SHP_ERR_NONE     2'h0
`define SHP_ERR_SYNTAX   2'h1
`define SHP_ERR_PARITY   2'h2
`define SHP_ERR_OVERRUN  2'h3

`endif

// ---- hw/shp_msg_ram.v ----
/*
  receive message buffer: one write port, one read port, registered read data.
  assumes the caller bounds the write address to the buffer depth.
*/
`timescale 1ns/100ps
`default_nettype none
`include "shp_defs.vh"

module shp_msg_ram (
  input  wire                    clk_i,
  input  wire                    we_i,
  input  wire [`SHP_BUF_AW-1:0]  waddr_i,
  input  wire [7:0]              wdata_i,
  input  wire [`SHP_BUF_AW-1:0]  raddr_i,
  output reg  [7:0]              rdata_o
);
  reg [7:0] mem [0:`SHP_BUF_DEPTH-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

// ---- hw/shp_skid_buf.v ----
/*
  two-entry buffer with valid/ready on both sides for reply characters.
  assumes a single clock and asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module shp_skid_buf (
  input  wire       clk_i,
  input  wire       reset_i,
  input  wire       in_valid_i,
  output wire       in_ready_o,
  input  wire [7:0] in_data_i,
  output wire       out_valid_o,
  input  wire       out_ready_i,
  output wire [7:0] out_data_o
);
  reg [7:0] ent_ff [0:1];
  reg       rd_ff;
  reg       wr_ff;
  reg [1:0] cnt_ff;
  wire      push;
  wire      pop;

  assign in_ready_o  = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o  = ent_ff[rd_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_ff     <= 1'b0;
      wr_ff     <= 1'b0;
      cnt_ff    <= 2'h0;
      ent_ff[0] <= 8'h00;
      ent_ff[1] <= 8'h00;
    end else begin
      if (push) begin
        ent_ff[wr_ff] <= in_data_i;
        wr_ff         <= ~wr_ff;
      end
      if (pop) begin
        rd_ff <= ~rd_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ---- tb/shp_port_chk.sv ----
/*
  concurrent checks on the pins of shp_port.
  assumes the baud switches select 9600 for the whole run.
*/
`timescale 1ns/100ps
`default_nettype none
`include "shp_defs.vh"

module shp_port_chk #(
  parameter int BIT_CYC = `SHP_DIV_9600
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sw_rts_open_i,
  input wire logic sw_force_cts_i,
  input wire logic sw_force_dsr_i,
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic rxd_i,
  input wire logic txd_o,
  input wire logic rts_o,
  input wire logic dtr_o,
  input wire logic msg_ready_o
);
  localparam int IDLE_CYC = 11 * BIT_CYC;
  logic [19:0] hi_cnt_ff;
  wire         cts_ok = (cts_i | sw_force_cts_i) & (dsr_i | sw_force_dsr_i);
  wire         hold   = rts_o ^ sw_rts_open_i;

  // a high run longer than a frame is idle line, not a stop bit
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i)
      hi_cnt_ff <= 20'h0;
    else if (!txd_o)
      hi_cnt_ff <= 20'h0;
    else if (hi_cnt_ff < 20'(IDLE_CYC))
      hi_cnt_ff <= hi_cnt_ff + 20'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  dtr_always_on_a: assert property (!$past(reset_i) |-> dtr_o)
    else $error("dtr dropped");
  rts_reset_idle_a: assert property ($fell(reset_i) |-> !rts_o ##1 !hold)
    else $error("rts not negated after reset");
  hold_after_msg_a: assert property (msg_ready_o |-> !hold ##1 !msg_ready_o ##1 hold)
    else $error("holdoff not raised 2 cycles after message");
  hold_cause_a: assert property ($rose(hold) && !$past(reset_i, 2) |-> $past(msg_ready_o, 2))
    else $error("holdoff raised without message");
  tx_in_hold_a: assert property (!txd_o |-> hold)
    else $error("transmit outside holdoff");
  hold_drop_a: assert property ($fell(hold) && !$past(reset_i, 2)
    |-> txd_o && hi_cnt_ff >= 20'(BIT_CYC))
    else $error("holdoff dropped before stop bit done");
  tx_paced_a: assert property ($fell(txd_o) && hi_cnt_ff == 20'(IDLE_CYC) |-> $past(cts_ok))
    else $error("character started without cts and dsr");
  msg_on_stop_a: assert property (msg_ready_o |-> rxd_i && $stable(rxd_i))
    else $error("message end away from stop bit");

  msg_seen_c: cover property (msg_ready_o);
  tx_start_c: cover property ($fell(txd_o));
  hold_end_c: cover property ($fell(hold));
endmodule
`default_nettype wire

// ---- tb/shp_host_model.sv ----
/*
  host computer on the serial cable: sends framed characters, decodes replies.
  assumes 8 data bits, no parity, one stop bit; rts_i is the holdoff level.
*/
`timescale 1ns/100ps
`default_nettype none

module shp_host_model #(
  parameter int BIT_CYC = 26041
) (
  input  wire logic clk_i,
  input  wire logic txd_i,
  input  wire logic rts_i,
  output var  logic rxd_o,
  output var  logic dcd_o
);
  logic [7:0] rx_q [0:7];
  logic [7:0] rx_sh;
  int         rx_cnt = 0;

  initial begin
    rxd_o = 1'b1;
    dcd_o = 1'b1;
  end

  // car low drops carrier for the whole character
  task automatic send(input logic [7:0] b, input logic car);
    int n;
    n = 0;
    while (rts_i && n < 8 * BIT_CYC) begin
      @(negedge clk_i);
      n++;
    end
    dcd_o = car;
    for (int i = -1; i < 9; i++) begin
      @(negedge clk_i);
      rxd_o = (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i];
      repeat (BIT_CYC - 1) @(negedge clk_i);
    end
    dcd_o = 1'b1;
  endtask

  always begin
    @(negedge txd_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      rx_sh[i] = txd_i;
    end
    rx_q[rx_cnt % 8] = rx_sh;
    rx_cnt++;
    repeat (BIT_CYC) @(posedge clk_i);
  end
endmodule
`default_nettype wire

// ---- tb/shp_port_bench.sv ----
/*
  self-checking bench of shp_port with the host model on the serial side.
  assumes 9600 baud, 8 data bits, no parity, one stop bit.
*/
`timescale 1ns/100ps
`default_nettype none
`include "shp_defs.vh"

module shp_port_bench;
  // bit times cut by a power of two to keep the run short
  localparam int SHIFT = 11;
  localparam int BIT = `SHP_DIV_9600 >> SHIFT;
  logic       clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       cts_i = 1'b0;
  logic       dsr_i = 1'b1;
  logic       f_dcd = 1'b0;
  logic       r_open = 1'b0;
  logic       f_hs = 1'b0;
  int         n_msg = 0;
  logic       vld = 1'b0;
  logic [7:0] dat = 8'h00;
  logic [5:0] raddr = 6'h00;
  logic [7:0] rep [0:2] = '{8'h4f, 8'h4b, 8'h0a};
  wire        txd_o, rts_o, dtr_o, rdy, rdy_o, rxd, dcd;
  wire  [6:0] len;
  wire  [1:0] merr;
  wire  [7:0] rdata;
  int         err_count = 0;
  int         compares = 0;

  initial forever #2 clk_i = ~clk_i;

  // the pulse may come while the host is still sending, so it is counted
  always @(negedge clk_i)
    if (rdy === 1'b1)
      n_msg <= n_msg + 1;

  shp_port #(.RATE_SHIFT(SHIFT)) dut (.clk_i(clk_i), .reset_i(reset_i), .sw_baud_i(3'h7),
    .sw_eight_bits_i(1'b1), .sw_parity_i(`SHP_PAR_NONE), .sw_two_stop_i(1'b0),
    .sw_force_dcd_i(f_dcd), .sw_force_cts_i(f_hs), .sw_force_dsr_i(f_hs),
    .sw_rts_open_i(r_open), .rxd_i(rxd), .cts_i(cts_i), .dsr_i(dsr_i), .dcd_i(dcd),
    .txd_o(txd_o), .rts_o(rts_o), .dtr_o(dtr_o), .msg_ready_o(rdy), .msg_len_o(len),
    .msg_err_o(merr), .msg_raddr_i(raddr), .msg_rdata_o(rdata),
    .reply_valid_i(vld), .reply_ready_o(rdy_o), .reply_data_i(dat));

  shp_host_model #(.BIT_CYC(BIT)) host (.clk_i(clk_i), .txd_i(txd_o),
    .rts_i(rts_o ^ r_open), .rxd_o(rxd), .dcd_o(dcd));

  task automatic results;
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  // wait_for: 0 messages counted, 1 reply bytes seen, 2 holdoff gone
  task automatic wait_for(input int what, input int goal, input int lim);
    int n;
    n = 0;
    while (!((what == 0 && n_msg == goal) || (what == 1 && host.rx_cnt == goal)
             || (what == 2 && rts_o === 1'b0)) && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= lim) begin
      check(1'b0, "wait ran out");
      results();
    end
  endtask

  task automatic do_reset;
    @(negedge clk_i);
    reset_i = 1'b1;
    repeat (20) @(negedge clk_i);
    check(txd_o === 1'b1 && rts_o === 1'b0 && dtr_o === 1'b0, "reset outputs");
    reset_i = 1'b0;
    @(posedge clk_i);
    #1;
    check(dtr_o === 1'b1 && rts_o === r_open, "first edge outputs");
    repeat (2) @(posedge clk_i);
  endtask

  // valid and data stand through the edge after a negedge that saw ready
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk_i);
    vld = 1'b1;
    dat = b;
    while (rdy_o !== 1'b1 && n < 50 * BIT) begin
      @(negedge clk_i);
      n++;
    end
    check(n < 50 * BIT, "reply byte not taken");
    @(negedge clk_i);
    vld = 1'b0;
  endtask

  initial begin
    do_reset();
    host.send(8'h4b, 1'b1);
    host.send(`SHP_CHAR_LF, 1'b1);
    wait_for(0, 1, 4 * BIT);
    check(len === 7'h01 && merr === `SHP_ERR_NONE, "message status");
    repeat (3) @(posedge clk_i);
    check(rts_o === 1'b1, "holdoff");
    @(posedge clk_i);
    #1;
    check(rdata === 8'h4b, "stored byte");
    put(rep[0]);
    put(rep[1]);
    repeat (4) @(negedge clk_i);
    check(rdy_o === 1'b0, "buffer full not refused");
    repeat (2 * BIT) @(negedge clk_i);
    check(host.rx_cnt == 0 && txd_o === 1'b1, "sent without cts");
    cts_i = 1'b1;
    put(rep[2]);
    wait_for(1, 3, 40 * BIT);
    for (int i = 0; i < 3; i++)
      check(host.rx_q[i] === rep[i], "reply byte");
    wait_for(2, 0, 4 * BIT);
    host.send(8'h5a, 1'b0);
    host.send(`SHP_CHAR_LF, 1'b1);
    wait_for(0, 2, 4 * BIT);
    check(len === 7'h00 && merr === `SHP_ERR_SYNTAX, "carrier loss");
    f_dcd = 1'b1;
    r_open = 1'b1;
    f_hs = 1'b1;
    cts_i = 1'b0;
    dsr_i = 1'b0;
    do_reset();
    check(rts_o === 1'b1, "inverted idle rts");
    host.send(8'h5a, 1'b0);
    host.send(`SHP_CHAR_LF, 1'b0);
    wait_for(0, 3, 4 * BIT);
    check(len === 7'h01 && merr === `SHP_ERR_NONE, "forced carrier");
    repeat (3) @(posedge clk_i);
    check(rts_o === 1'b0, "inverted holdoff");
    put(`SHP_CHAR_LF);
    wait_for(1, 4, 12 * BIT);
    check(host.rx_q[3] === `SHP_CHAR_LF, "forced cts and dsr");
    results();
  end
endmodule

bind shp_port shp_port_chk #(.BIT_CYC(`SHP_DIV_9600 >> RATE_SHIFT)) chk (
  .clk_i(clk_i), .reset_i(reset_i),
  .sw_rts_open_i(sw_rts_open_i), .sw_force_cts_i(sw_force_cts_i),
  .sw_force_dsr_i(sw_force_dsr_i), .cts_i(cts_i), .dsr_i(dsr_i), .rxd_i(rxd_i),
  .txd_o(txd_o), .rts_o(rts_o), .dtr_o(dtr_o), .msg_ready_o(msg_ready_o));
`default_nettype wire
